// >>> hdl/uhirq_bank.v
// event flags, interrupt masks and list pointer registers of the host controller
// assumes the core supplies one-cycle event pulses and a synchronous register port
`timescale 1ns/1ps
`default_nettype none
`include "uhirq_consts.vh"
module uhirq_bank (
    input  wire        clk_in,
    input  wire        reset_in,
    input  wire        soft_reset_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        routing_select_in,
    input  wire        frame_start_in,
    input  wire        overrun_in,
    input  wire        resume_signal_in,
    input  wire        resume_state_in,
    input  wire        system_error_in,
    input  wire        error_fixed_in,
    input  wire [15:0] frame_counter_in,
    input  wire        root_hub_change_in,
    input  wire        ownership_request_in,
    input  wire        periodic_done_in,
    input  wire [31:0] periodic_ptr_in,
    input  wire        td_complete_in,
    input  wire [31:0] td_addr_in,
    input  wire        done_copy_req_in,
    input  wire        ctrl_advance_in,
    input  wire [31:0] ctrl_next_in,
    input  wire        ctrl_end_in,
    input  wire        control_list_filled_flag_in,
    input  wire        bulk_advance_in,
    input  wire [31:0] bulk_next_in,
    input  wire        bulk_end_in,
    input  wire        bulk_list_filled_flag_in,
    output reg  [31:0] reg_rdata_out,
    output reg         host_irq_out,
    output reg         smi_irq_out,
    output reg         sof_token_out,
    output reg  [1:0]  overrun_count_out,
    output reg         halt_out,
    output reg         done_copy_out,
    output reg  [31:0] done_copy_ptr_out,
    output reg  [31:0] td_next_out,
    output reg         td_next_wr_out,
    output reg  [14:0] largest_packet_count_out,
    output reg  [31:0] control_head_out,
    output reg  [31:0] bulk_head_out,
    output reg         ctrl_filled_clear_out,
    output reg         bulk_filled_clear_out
);
    // ******************************************************
    // decode
    // ******************************************************
    wire any_reset = reset_in | soft_reset_in;
    wire wr_flags  = reg_wr_in & (reg_addr_in == `UHIRQ_OFS_FLAGS);
    wire wr_mset   = reg_wr_in & (reg_addr_in == `UHIRQ_OFS_MSET);
    wire wr_mclr   = reg_wr_in & (reg_addr_in == `UHIRQ_OFS_MCLR);
    wire wr_area   = reg_wr_in & (reg_addr_in == `UHIRQ_OFS_AREA);
    wire wr_chead  = reg_wr_in & (reg_addr_in == `UHIRQ_OFS_CHEAD);
    wire wr_ccur   = reg_wr_in & (reg_addr_in == `UHIRQ_OFS_CCUR);
    wire wr_bhead  = reg_wr_in & (reg_addr_in == `UHIRQ_OFS_BHEAD);
    wire wr_bcur   = reg_wr_in & (reg_addr_in == `UHIRQ_OFS_BCUR);
    wire wr_fper   = reg_wr_in & (reg_addr_in == `UHIRQ_OFS_FPER);

    // ******************************************************
    // event sources
    // ******************************************************
    reg         resume_seen_reg;
    reg         frame_msb_reg;
    reg         err_latched_reg;
    reg  [31:0] done_head_reg;
    wire [31:0] flags;

    // frame count from core is already written to the shared area when it changes
    wire wrap_evt   = (frame_counter_in[`UHIRQ_FRAME_MSB] != frame_msb_reg);
    wire resume_evt = resume_signal_in & ~resume_seen_reg & ~resume_state_in;
    // a copy request is held off while the previous copy is unsaved
    wire copy_go    = done_copy_req_in & ~flags[`UHIRQ_BIT_WDH] & ~err_latched_reg;

    wire [31:0] set_vec = {1'b0, ownership_request_in, 23'h0,
                           root_hub_change_in,
                           wrap_evt,
                           system_error_in,
                           resume_evt,
                           frame_start_in & ~err_latched_reg,
                           copy_go,
                           overrun_in};

    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : evt
            if (((`UHIRQ_EVT_MASK >> g) & 1) == 1) begin : live
                uhirq_event_bit u_bit (
                    .clk_in   (clk_in),
                    .reset_in (any_reset),
                    .set_in   (set_vec[g]),
                    .clear_in (wr_flags & reg_wdata_in[g]),
                    .flag_out (flags[g])
                );
            end else begin : tie
                assign flags[g] = 1'b0;
            end
        end
    endgenerate

    // ******************************************************
    // masks, pointers, configuration
    // ******************************************************
    reg  [31:0] mask_reg;
    reg  [31:0] area_reg;
    reg  [31:0] pcur_reg;
    reg  [31:0] fper_reg;
    wire [31:0] ccur;
    wire [31:0] bcur;
    wire        c_clr;
    wire        b_clr;

    always @(posedge clk_in) begin
        if (any_reset) begin
            mask_reg <= 32'h00000000;
            fper_reg <= `UHIRQ_FPER_RESET;
        end else begin
            if (wr_mset) begin
                mask_reg <= mask_reg | (reg_wdata_in & (`UHIRQ_EVT_MASK | 32'h80000000));
            end else if (wr_mclr) begin
                mask_reg <= mask_reg & ~reg_wdata_in;
            end
            if (wr_fper) begin
                fper_reg <= reg_wdata_in & `UHIRQ_FPER_MASK;
            end
        end
    end

    always @(posedge clk_in) begin
        if (any_reset) begin
            area_reg         <= 32'h00000000;
            pcur_reg         <= 32'h00000000;
            control_head_out <= 32'h00000000;
            bulk_head_out    <= 32'h00000000;
            resume_seen_reg  <= 1'b0;
            frame_msb_reg    <= 1'b0;
            err_latched_reg  <= 1'b0;
            done_head_reg    <= 32'h00000000;
        end else begin
            if (wr_area) begin
                area_reg <= reg_wdata_in & `UHIRQ_AREA_MASK;
            end
            if (periodic_done_in) begin
                pcur_reg <= periodic_ptr_in & `UHIRQ_PTR_MASK;
            end
            if (wr_chead) begin
                control_head_out <= reg_wdata_in & `UHIRQ_PTR_MASK;
            end
            if (wr_bhead) begin
                bulk_head_out <= reg_wdata_in & `UHIRQ_PTR_MASK;
            end
            resume_seen_reg <= resume_signal_in;
            frame_msb_reg   <= frame_counter_in[`UHIRQ_FRAME_MSB];
            if (system_error_in) begin
                err_latched_reg <= 1'b1;
            end else if (error_fixed_in) begin
                err_latched_reg <= 1'b0;
            end
            // a descriptor finishing in the copy cycle starts the new queue, so none is lost
            if (td_complete_in & ~err_latched_reg) begin
                done_head_reg <= td_addr_in & `UHIRQ_PTR_MASK;
            end else if (copy_go) begin
                done_head_reg <= 32'h00000000;
            end
        end
    end

    uhirq_list_walker u_ctrl (
        .clk_in           (clk_in),
        .reset_in         (any_reset),
        .wr_in            (wr_ccur),
        .wr_data_in       (reg_wdata_in),
        .advance_in       (ctrl_advance_in & ~err_latched_reg),
        .next_ptr_in      (ctrl_next_in),
        .list_end_in      (ctrl_end_in & ~err_latched_reg),
        .filled_in        (control_list_filled_flag_in),
        .head_in          (control_head_out),
        .current_out      (ccur),
        .filled_clear_out (c_clr)
    );

    uhirq_list_walker u_bulk (
        .clk_in           (clk_in),
        .reset_in         (any_reset),
        .wr_in            (wr_bcur),
        .wr_data_in       (reg_wdata_in),
        .advance_in       (bulk_advance_in & ~err_latched_reg),
        .next_ptr_in      (bulk_next_in),
        .list_end_in      (bulk_end_in & ~err_latched_reg),
        .filled_in        (bulk_list_filled_flag_in),
        .head_in          (bulk_head_out),
        .current_out      (bcur),
        .filled_clear_out (b_clr)
    );

    // ******************************************************
    // outputs
    // ******************************************************
    wire irq_any = mask_reg[`UHIRQ_BIT_MIE] & (|(flags & mask_reg & `UHIRQ_EVT_MASK));
    wire own_smi = flags[`UHIRQ_BIT_OWN] & mask_reg[`UHIRQ_BIT_OWN] & mask_reg[`UHIRQ_BIT_MIE];

    reg [31:0] rdata_next;
    always @* begin
        case (reg_addr_in)
            `UHIRQ_OFS_FLAGS: rdata_next = flags;
            `UHIRQ_OFS_MSET:  rdata_next = mask_reg;
            `UHIRQ_OFS_MCLR:  rdata_next = {~mask_reg[`UHIRQ_BIT_MIE], mask_reg[30:0]};
            `UHIRQ_OFS_AREA:  rdata_next = area_reg;
            `UHIRQ_OFS_PCUR:  rdata_next = pcur_reg;
            `UHIRQ_OFS_CHEAD: rdata_next = control_head_out;
            `UHIRQ_OFS_CCUR:  rdata_next = ccur;
            `UHIRQ_OFS_BHEAD: rdata_next = bulk_head_out;
            `UHIRQ_OFS_BCUR:  rdata_next = bcur;
            `UHIRQ_OFS_DONE:  rdata_next = done_head_reg;
            `UHIRQ_OFS_FPER:  rdata_next = fper_reg;
            default:          rdata_next = 32'h00000000;
        endcase
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            reg_rdata_out            <= 32'h00000000;
            host_irq_out             <= 1'b0;
            smi_irq_out              <= 1'b0;
            sof_token_out            <= 1'b0;
            overrun_count_out        <= 2'h0;
            halt_out                 <= 1'b0;
            done_copy_out            <= 1'b0;
            done_copy_ptr_out        <= 32'h00000000;
            td_next_out              <= 32'h00000000;
            td_next_wr_out           <= 1'b0;
            largest_packet_count_out <= 15'h0000;
            ctrl_filled_clear_out    <= 1'b0;
            bulk_filled_clear_out    <= 1'b0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rdata_next : 32'h00000000;
            host_irq_out  <= irq_any & ~routing_select_in;
            smi_irq_out   <= (irq_any & routing_select_in) | own_smi;
            sof_token_out <= frame_start_in & ~err_latched_reg;
            if (soft_reset_in) begin
                overrun_count_out <= 2'h0;
            end else if (overrun_in) begin
                overrun_count_out <= overrun_count_out + 2'h1;
            end
            halt_out          <= err_latched_reg | system_error_in;
            done_copy_out     <= copy_go;
            done_copy_ptr_out <= done_head_reg;
            td_next_wr_out    <= td_complete_in & ~err_latched_reg;
            td_next_out       <= copy_go ? 32'h00000000 : done_head_reg;
            if (frame_start_in) begin
                largest_packet_count_out <= fper_reg[30:16];
            end
            ctrl_filled_clear_out <= c_clr;
            bulk_filled_clear_out <= b_clr;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/uhirq_consts.vh
// constants for the host controller event, mask and list pointer register bank
// assumes a 32-bit register port with word offsets as printed
// Overview of operation
// - overrun sets bit 0 after frame number update and bumps overrun count
// - done-head flag bit 1 set after copy; no further copy until cleared
// - each frame start sets bit 2 together with the start token
// - resume flag bit 3 set on rising resume signaling, not software resume
// - fatal system error sets bit 4 and halts frame start, descriptor, done copy and list processing
// - frame wrap flag bit 5 set when frame count bit 15 toggles
// - root hub change flag bit 6 set on any root hub status change
// - ownership request sets bit 30; unmasked with master bit set raises management interrupt
// - writing one at offset 10h enables an event; zero ignored
// - bit 31 master gate set by writing one; zero ignored
// - writing one at offset 14h disables event or master; zero ignored
// - after any reset master bit reads set in disable register
// - shared area base bits 31:8, reset zero, low byte reserved
// - periodic current pointer updated by device, read only
// - control and bulk traversal start from head pointers, bits 31:4
// - control current advances, zero ends list, reload if filled flag set
// - bulk current behaves the same using bulk head and bulk filled flag
// - completed descriptor links old done head, becomes new done head
// - frame period bits 13:0 reset to 2EDFh on any reset
// - largest packet counter loaded from bits 30:16 each frame
// - routing bit steers interrupts to normal or management line
// - two-bit overrun counter starts zero, counts every overrun, wraps
`ifndef UHIRQ_CONSTS_VH
`define UHIRQ_CONSTS_VH
`define UHIRQ_OFS_FLAGS    8'h0C
`define UHIRQ_OFS_MSET     8'h10
`define UHIRQ_OFS_MCLR     8'h14
`define UHIRQ_OFS_AREA     8'h18
`define UHIRQ_OFS_PCUR     8'h1C
`define UHIRQ_OFS_CHEAD    8'h20
`define UHIRQ_OFS_CCUR     8'h24
`define UHIRQ_OFS_BHEAD    8'h28
`define UHIRQ_OFS_BCUR     8'h2C
`define UHIRQ_OFS_DONE     8'h30
`define UHIRQ_OFS_FPER     8'h34
`define UHIRQ_BIT_OVR      0
`define UHIRQ_BIT_WDH      1
`define UHIRQ_BIT_SOF      2
`define UHIRQ_BIT_RES      3
`define UHIRQ_BIT_ERR      4
`define UHIRQ_BIT_WRAP     5
`define UHIRQ_BIT_RHC      6
`define UHIRQ_BIT_OWN      30
`define UHIRQ_BIT_MIE      31
`define UHIRQ_EVT_MASK     32'h4000007F
`define UHIRQ_AREA_MASK    32'hFFFFFF00
`define UHIRQ_PTR_MASK     32'hFFFFFFF0
`define UHIRQ_FPER_MASK    32'hFFFF3FFF
`define UHIRQ_FPER_RESET   32'h00002EDF
`define UHIRQ_FRAME_MSB    15
`endif

// >>> hdl/uhirq_event_bit.v
// one sticky event flag with write-one-to-clear
// assumes set pulses and write strobes are synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module uhirq_event_bit (
    input  wire clk_in,
    input  wire reset_in,
    input  wire set_in,
    input  wire clear_in,
    output reg  flag_out
);
    // set wins over a clear in the same cycle
    always @(posedge clk_in) begin
        if (reset_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/uhirq_list_walker.v
// current descriptor pointer of one asynchronous list
// assumes the core pulses advance and end-of-list events one at a time
`timescale 1ns/1ps
`default_nettype none
`include "uhirq_consts.vh"
module uhirq_list_walker (
    input  wire        clk_in,
    input  wire        reset_in,
    input  wire        wr_in,
    input  wire [31:0] wr_data_in,
    input  wire        advance_in,
    input  wire [31:0] next_ptr_in,
    input  wire        list_end_in,
    input  wire        filled_in,
    input  wire [31:0] head_in,
    output reg  [31:0] current_out,
    output reg         filled_clear_out
);
    always @(posedge clk_in) begin
        if (reset_in) begin
            current_out      <= 32'h00000000;
            filled_clear_out <= 1'b0;
        end else begin
            filled_clear_out <= 1'b0;
            if (list_end_in) begin
                if (filled_in) begin
                    current_out      <= head_in & `UHIRQ_PTR_MASK;
                    filled_clear_out <= 1'b1;
                end else begin
                    current_out <= 32'h00000000;
                end
            end else if (advance_in) begin
                current_out <= next_ptr_in & `UHIRQ_PTR_MASK;
            end else if (wr_in) begin
                // software must hold the list disabled while writing here
                current_out <= wr_data_in & `UHIRQ_PTR_MASK;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/uhirq_mem_model.sv
// shared-area memory model: keeps done-head copies and descriptor link writes
// assumes the bank pulses its write strobes for one clk_in cycle
`timescale 1ns/1ps
`default_nettype none
module uhirq_mem_model (
    input  wire logic        clk_in,
    input  wire logic        copy_in,
    input  wire logic [31:0] copy_ptr_in,
    input  wire logic        link_wr_in,
    input  wire logic [31:0] link_in,
    output var  logic [31:0] copies_out,
    output var  logic [31:0] saved_ptr_out,
    output var  logic [31:0] saved_link_out
);
    // unwritten words start at all ones so a missing write cannot look like zero
    initial begin
        copies_out = 32'h0;
        saved_ptr_out = 32'hFFFFFFFF;
        saved_link_out = 32'hFFFFFFFF;
    end
    always @(posedge clk_in) begin
        if (copy_in) begin
            copies_out <= copies_out + 32'h1;
            saved_ptr_out <= copy_ptr_in;
        end
        if (link_wr_in) begin
            saved_link_out <= link_in;
        end
    end
endmodule
`default_nettype wire

// >>> dv/uhirq_bank_asserts.sv
// timing checks on the event and list ports of the register bank
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module uhirq_bank_asserts (
    input wire logic       clk_in,
    input wire logic       reset_in,
    input wire logic       soft_reset_in,
    input wire logic       overrun_in,
    input wire logic       system_error_in,
    input wire logic       error_fixed_in,
    input wire logic       td_complete_in,
    input wire logic       frame_start_in,
    input wire logic       ctrl_end_in,
    input wire logic       control_list_filled_flag_in,
    input wire logic       bulk_end_in,
    input wire logic       bulk_list_filled_flag_in,
    input wire logic       sof_token_out,
    input wire logic [1:0] overrun_count_out,
    input wire logic       halt_out,
    input wire logic       td_next_wr_out,
    input wire logic       ctrl_filled_clear_out,
    input wire logic       bulk_filled_clear_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_ctrl_reload;
        ctrl_end_in && control_list_filled_flag_in && !halt_out && !soft_reset_in;
    endsequence
    sequence s_bulk_reload;
        bulk_end_in && bulk_list_filled_flag_in && !halt_out && !soft_reset_in;
    endsequence
    a_sof_with_frame: assert property (frame_start_in && !halt_out |-> ##[1:2] sof_token_out)
        else $error("start token missing after frame start");
    a_overrun_count_step: assert property (overrun_in && !soft_reset_in && !halt_out |=>
        overrun_count_out == $past(overrun_count_out) + 2'h1) else $error("overrun count did not step");
    a_error_halts: assert property (system_error_in |=> halt_out)
        else $error("halt missing after system error");
    a_halt_holds: assert property (halt_out && !error_fixed_in && !soft_reset_in && !$past(error_fixed_in) &&
        !$past(soft_reset_in) |=> halt_out)
        else $error("halt released without correction");
    a_td_link_write: assert property (td_complete_in && !halt_out |=> td_next_wr_out)
        else $error("descriptor link write missing");
    a_ctrl_reload_clear: assert property (s_ctrl_reload |-> ##2 ctrl_filled_clear_out)
        else $error("control filled flag not cleared");
    a_ctrl_idle_end: assert property (ctrl_end_in && !control_list_filled_flag_in |-> ##2 !ctrl_filled_clear_out)
        else $error("control filled clear without filled flag");
    a_bulk_reload_clear: assert property (s_bulk_reload |-> ##2 bulk_filled_clear_out)
        else $error("bulk filled flag not cleared");
endmodule
bind uhirq_bank uhirq_bank_asserts u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .soft_reset_in(soft_reset_in), .overrun_in(overrun_in),
    .system_error_in(system_error_in), .error_fixed_in(error_fixed_in), .td_complete_in(td_complete_in),
    .frame_start_in(frame_start_in), .ctrl_end_in(ctrl_end_in), .bulk_end_in(bulk_end_in),
    .control_list_filled_flag_in(control_list_filled_flag_in), .bulk_list_filled_flag_in(bulk_list_filled_flag_in),
    .sof_token_out(sof_token_out), .overrun_count_out(overrun_count_out), .halt_out(halt_out),
    .td_next_wr_out(td_next_wr_out), .ctrl_filled_clear_out(ctrl_filled_clear_out),
    .bulk_filled_clear_out(bulk_filled_clear_out));
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the event, mask and list pointer bank
// assumes the shared-area model stands on the bank's memory side
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        soft_reset_in = 1'b0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        routing = 1'b0;
    logic        res_sig = 1'b0;
    logic        res_state = 1'b0;
    logic        filled = 1'b0;
    logic [15:0] fcnt = 16'h0;
    logic [12:0] ev = 13'h0;
    logic [31:0] addr_val = 32'h0;
    logic [31:0] rdata, copy_ptr, td_next, copies, saved_ptr, saved_link;
    logic        host_irq, smi_irq, halt, copy_str, td_wr, sof;
    logic [1:0]  ovr_cnt;
    logic [14:0] lpc;
    logic [31:0] flag_bit [5] = '{32'h1, 32'h4, 32'h40, 32'h40000000, 32'h10};
    int          n_mismatch = 0;
    int          checked = 0;
    // ******************************
    // harness
    // ******************************
    uhirq_bank DUT (.clk_in(clk_in), .reset_in(reset_in), .soft_reset_in(soft_reset_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .routing_select_in(routing), .frame_start_in(ev[1]), .overrun_in(ev[0]), .resume_signal_in(res_sig),
        .resume_state_in(res_state), .system_error_in(ev[4]), .error_fixed_in(ev[5]), .frame_counter_in(fcnt),
        .root_hub_change_in(ev[2]), .ownership_request_in(ev[3]), .periodic_done_in(ev[12]),
        .periodic_ptr_in(addr_val), .td_complete_in(ev[6]), .td_addr_in(addr_val), .done_copy_req_in(ev[7]),
        .ctrl_advance_in(ev[8]), .ctrl_next_in(addr_val), .ctrl_end_in(ev[9]), .control_list_filled_flag_in(filled),
        .bulk_advance_in(ev[10]), .bulk_next_in(addr_val), .bulk_end_in(ev[11]), .bulk_list_filled_flag_in(filled),
        .reg_rdata_out(rdata), .host_irq_out(host_irq), .smi_irq_out(smi_irq), .sof_token_out(sof),
        .overrun_count_out(ovr_cnt), .halt_out(halt), .done_copy_out(copy_str), .done_copy_ptr_out(copy_ptr),
        .td_next_out(td_next), .td_next_wr_out(td_wr), .largest_packet_count_out(lpc), .control_head_out(),
        .bulk_head_out(), .ctrl_filled_clear_out(), .bulk_filled_clear_out());
    uhirq_mem_model MEM (.clk_in(clk_in), .copy_in(copy_str), .copy_ptr_in(copy_ptr), .link_wr_in(td_wr),
        .link_in(td_next), .copies_out(copies), .saved_ptr_out(saved_ptr), .saved_link_out(saved_link));
    always #20 clk_in = ~clk_in;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // outputs are sampled mid-cycle so edge updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task automatic pulse(input logic [12:0] m);
        @(posedge clk_in);
        ev <= m;
        @(posedge clk_in);
        ev <= 13'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        chk($sformatf("reg %h", a), rdata, exp);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_in);
        n_mismatch++;
        print_verdict;
    end
    // ******************************
    // scenarios
    // ******************************
    initial begin
        cyc(2);
        reset_in <= 1'b0;
        rd(8'h34, 32'h00002EDF);
        rd(8'h24, 32'h0);
        rd(8'h14, 32'h80000000);
        for (int i = 0; i < 5; i++) begin
            pulse(13'h1 << i);
            wr(8'h0C, 32'h0);
            rd(8'h0C, flag_bit[i]);
            wr(8'h0C, flag_bit[i]);
            rd(8'h0C, 32'h0);
        end
        settle(0);
        chk("halt", 32'(halt), 32'h1);
        pulse(13'h20);
        settle(1);
        chk("halt", 32'(halt), 32'h0);
        pulse(13'h1);
        pulse(13'h1);
        settle(0);
        chk("overrun count", 32'(ovr_cnt), 32'h3);
        pulse(13'h1);
        settle(0);
        chk("overrun count", 32'(ovr_cnt), 32'h0);
        $display("test events done");
        wr(8'h10, 32'h80000001);
        wr(8'h10, 32'h0);
        rd(8'h10, 32'h80000001);
        settle(2);
        chk("host irq", 32'(host_irq), 32'h1);
        cyc(1);
        routing <= 1'b1;
        settle(3);
        chk("smi irq", 32'(smi_irq), 32'h1);
        chk("host irq", 32'(host_irq), 32'h0);
        cyc(1);
        routing <= 1'b0;
        wr(8'h14, 32'h80000000);
        settle(2);
        chk("host irq", 32'(host_irq), 32'h0);
        wr(8'h14, 32'h1);
        rd(8'h10, 32'h0);
        wr(8'h0C, 32'h1);
        $display("test masks done");
        cyc(1);
        res_sig <= 1'b1;
        rd(8'h0C, 32'h8);
        wr(8'h0C, 32'h8);
        res_sig <= 1'b0;
        cyc(1);
        res_state <= 1'b1;
        res_sig <= 1'b1;
        rd(8'h0C, 32'h0);
        cyc(1);
        fcnt <= 16'h8000;
        rd(8'h0C, 32'h20);
        wr(8'h0C, 32'h20);
        fcnt <= 16'h0;
        rd(8'h0C, 32'h20);
        wr(8'h0C, 32'h20);
        $display("test resume and wrap done");
        for (int k = 1; k < 3; k++) begin
            cyc(1);
            addr_val <= 32'h100 * k;
            pulse(13'h40);
            settle(1);
            chk("link", saved_link, 32'h100 * (k - 1));
            rd(8'h30, 32'h100 * k);
        end
        pulse(13'h80);
        settle(2);
        chk("copied head", saved_ptr, 32'h200);
        rd(8'h30, 32'h0);
        rd(8'h0C, 32'h2);
        pulse(13'h80);
        settle(2);
        chk("copies", copies, 32'h1);
        wr(8'h0C, 32'h2);
        $display("test done queue done");
        for (int j = 0; j < 2; j++) begin
            wr(8'(8'h20 + 8 * j), 32'h12345678);
            rd(8'(8'h20 + 8 * j), 32'h12345670);
            cyc(1);
            addr_val <= 32'hABCD;
            pulse(13'h100 << (2 * j));
            rd(8'(8'h24 + 8 * j), 32'hABC0);
            cyc(1);
            filled <= 1'b1;
            pulse(13'h200 << (2 * j));
            filled <= 1'b0;
            rd(8'(8'h24 + 8 * j), 32'h12345670);
            pulse(13'h200 << (2 * j));
            rd(8'(8'h24 + 8 * j), 32'h0);
            wr(8'(8'h24 + 8 * j), 32'h0000FFFF);
            rd(8'(8'h24 + 8 * j), 32'h0000FFF0);
        end
        $display("test lists done");
        wr(8'h18, 32'hFFFFFFFF);
        rd(8'h18, 32'hFFFFFF00);
        cyc(1);
        addr_val <= 32'hCAFEBABF;
        pulse(13'h1000);
        wr(8'h1C, 32'h0);
        rd(8'h1C, 32'hCAFEBAB0);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0);
        wr(8'h34, 32'hFFFFFFFF);
        rd(8'h34, 32'hFFFF3FFF);
        pulse(13'h2);
        settle(0);
        chk("sof token", 32'(sof), 32'h1);
        chk("packet count", 32'(lpc), 32'h7FFF);
        wr(8'h0C, 32'h4);
        soft_reset_in <= 1'b1;
        cyc(1);
        soft_reset_in <= 1'b0;
        rd(8'h34, 32'h00002EDF);
        rd(8'h18, 32'h0);
        rd(8'h14, 32'h80000000);
        $display("test config and soft reset done");
        print_verdict;
    end
endmodule
`default_nettype wire
